// ---- src/csr_pkg.sv ----
// Package of constants and carrier types for the CPU clock speed and reset release block
package csr_pkg;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int unsigned RELEASE_PERIODS     = 1024;
  localparam int unsigned STD_PERIODS_PER_MC  = 12;
  localparam int unsigned X2_PERIODS_PER_MC   = 6;
  localparam int unsigned CNT_WIDTH           = 11;

  // ----------------------------------------------------------------
  // Peripheral selection field positions
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PERIPH          = 7;
  localparam int unsigned PER_TIMER0          = 0;
  localparam int unsigned PER_TIMER1          = 1;
  localparam int unsigned PER_TIMER2          = 2;
  localparam int unsigned PER_SERIAL          = 3;
  localparam int unsigned PER_COUNTER_ARRAY   = 4;
  localparam int unsigned PER_WATCHDOG        = 5;
  localparam int unsigned PER_CAN             = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  PHASE_RESET         = 4'h0;
  localparam logic [10:0] COUNT_RESET         = 11'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RST_WAIT_SUPPLY = 2'b00,
    RST_WAIT_TOGGLE = 2'b01,
    RST_COUNTING    = 2'b10,
    RST_RELEASED    = 2'b11
  } csr_rst_state_type;

  typedef struct packed {
    logic                  cpuTick;
    logic                  machineCycle;
    logic [NUM_PERIPH-1:0] periphTick;
  } csr_ticks_type;

endpackage : csr_pkg

// ---- src/csr_release_counter.sv ----
// Reset release sequencer: supply, crystal toggle and 1024-period count
`timescale 1ns/1ps
module csr_release_counter
  import csr_pkg::*;
#(
  parameter int unsigned COUNT = RELEASE_PERIODS
) (
  input  wire logic mclk,          // System clock
  input  wire logic rst,           // Async reset, active high
  input  wire logic supplyOk,      // Synchronised supply monitor level
  input  wire logic xtalSync,      // Synchronised crystal input
  output logic      resetActive,   // Internal reset, registered
  output logic      toggleSeen     // Crystal toggle observed, AND of registered flags
);

  typedef struct packed {
    csr_rst_state_type     state;
    logic [CNT_WIDTH-1:0]  count;
    logic                  xtalLast;
    logic                  sawLow;
    logic                  sawHigh;
    logic                  resetActive;
  } csr_rc_state_type;

  csr_rc_state_type s_q;
  csr_rc_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.xtalLast = xtalSync;
    unique case (s_q.state)
      RST_WAIT_SUPPLY: begin
        s_d.resetActive = 1'b1;
        s_d.count       = COUNT_RESET;
        if (supplyOk) begin
          s_d.state = RST_WAIT_TOGGLE;
        end
      end
      RST_WAIT_TOGGLE: begin
        if (!xtalSync) begin
          s_d.sawLow = 1'b1;
        end
        if (xtalSync) begin
          s_d.sawHigh = 1'b1;
        end
        if (s_q.sawLow && s_q.sawHigh) begin
          s_d.state = RST_COUNTING; // [RULE11]
        end
      end
      RST_COUNTING: begin
        if (s_q.xtalLast && !xtalSync) begin
          s_d.count = s_q.count + 11'h001; // [RULE12]
        end
        if (s_q.count == COUNT[CNT_WIDTH-1:0]) begin
          s_d.state       = RST_RELEASED;
          s_d.resetActive = 1'b0; // [RULE12]
        end
      end
      RST_RELEASED: begin
        s_d.resetActive = 1'b0;
      end
    endcase
    // Supply drop restarts everything
    if (!supplyOk) begin
      s_d.state       = RST_WAIT_SUPPLY; // [RULE14]
      s_d.count       = COUNT_RESET;
      s_d.sawLow      = 1'b0;
      s_d.sawHigh     = 1'b0;
      s_d.resetActive = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{state: RST_WAIT_SUPPLY, count: COUNT_RESET, xtalLast: 1'b0,
               sawLow: 1'b0, sawHigh: 1'b0, resetActive: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign resetActive = s_q.resetActive;
  assign toggleSeen  = s_q.sawLow & s_q.sawHigh;

endmodule // csr_release_counter

// ---- src/csr_clock_speed.sv ----
// CPU clock speed selection and internal reset release
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Double speed: 6 periods per machine cycle
// [RULE2] Standard speed halves crystal before core
// [RULE3] Software bit disables the halving stage
// [RULE4] Select bit switches 12 to 6 periods
// [RULE5] Reset leaves standard speed unless boot option
// [RULE6] Select bit changes CPU clock only; code also doubles peripherals whose periphStdSelect bit is clear
// [RULE7] Peripheral doubles only when own bit clear
// [RULE8] Double speed bypasses halving stage
// [RULE9] Mode change only on halved-clock rising edge
// [RULE10] Boot option starts in double speed
// [RULE11] Hold reset until crystal seen toggling
// [RULE12] Then count 1024 periods, release reset
// [RULE13] Supply drop asserts reset immediately
// [RULE14] Halver and counter restart on reset
module csr_clock_speed
  import csr_pkg::*;
#(
  parameter int unsigned RELEASE_COUNT = RELEASE_PERIODS
) (
  input  wire logic                  mclk,               // System clock
  input  wire logic                  rst,                // Async reset, active high
  input  wire logic                  crystalInput,       // Crystal input pin, async
  input  wire logic                  supplyOk,           // Supply monitor, high = safe
  input  wire logic                  doubleSpeedSelect,  // Clock control: CPU double speed
  input  wire logic [NUM_PERIPH-1:0] periphStdSelect,    // Clock control: 1 keeps standard
  input  wire logic                  bootDoubleSpeed,    // Security byte boot option
  output logic                       internalReset,      // Internal reset, active high
  output logic                       cpuTick,            // Core clock enable pulse
  output logic                       machineCycle,       // One pulse per machine cycle
  output logic [NUM_PERIPH-1:0]      periphTick,         // Peripheral clock enable pulses
  output logic                       doubleSpeedActive,  // Applied CPU mode
  output logic                       crystalToggling     // Crystal activity seen
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] xtalSync_q;
  logic [1:0] supplySync_q;
  logic       resetActive;
  logic       toggleSeen;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xtalSync_q   <= 2'h0;
      supplySync_q <= 2'h0;
    end else begin
      xtalSync_q   <= {xtalSync_q[0], crystalInput};
      supplySync_q <= {supplySync_q[0], supplyOk};
    end
  end

  // ----------------------------------------------------------------
  // Reset release sequencer
  // ----------------------------------------------------------------
  csr_release_counter #(
    .COUNT       (RELEASE_COUNT)
  ) u_release (
    .mclk        (mclk),
    .rst         (rst),
    .supplyOk    (supplySync_q[1]),
    .xtalSync    (xtalSync_q[1]),
    .resetActive (resetActive),
    .toggleSeen  (toggleSeen)
  );

  // ----------------------------------------------------------------
  // Speed state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  xtalLast;
    logic                  halfClk;
    logic                  x2Mode;
    logic                  bootTaken;
    logic [3:0]            phase;
    csr_ticks_type         ticks;
    logic                  internalReset;
    logic                  toggling;
  } csr_speed_state_type;

  csr_speed_state_type s_q;
  csr_speed_state_type s_d;

  logic supplyLost;
  assign supplyLost = ~supplyOk;

  always_comb begin
    logic xtalRise;
    logic halfRise;
    logic [3:0] lastPhase;
    xtalRise  = 1'b0;
    halfRise  = 1'b0;
    lastPhase = 4'h0;
    s_d = s_q;
    s_d.toggling      = toggleSeen;
    s_d.internalReset = resetActive;
    s_d.xtalLast      = xtalSync_q[1];
    s_d.ticks         = '0;
    xtalRise = xtalSync_q[1] & ~s_q.xtalLast;
    if (resetActive) begin
      s_d.halfClk   = 1'b0; // [RULE14]
      s_d.phase     = PHASE_RESET;
      s_d.bootTaken = 1'b0;
      s_d.x2Mode    = 1'b0; // [RULE5]
    end else begin
      if (xtalRise) begin
        s_d.halfClk = ~s_q.halfClk; // [RULE2]
        halfRise    = ~s_q.halfClk;
      end
      if (!s_q.bootTaken) begin
        s_d.bootTaken = 1'b1;
        s_d.x2Mode    = bootDoubleSpeed; // [RULE10]
      end else if (halfRise) begin
        s_d.x2Mode = doubleSpeedSelect; // [RULE9] [RULE3] [RULE4]
      end
      // CPU ticks every crystal rise in double speed, every other otherwise
      s_d.ticks.cpuTick = s_q.x2Mode ? xtalRise : halfRise; // [RULE8] [RULE6]
      // Peripherals follow double speed only with their bit clear
      for (int i = 0; i < NUM_PERIPH; i++) begin
        s_d.ticks.periphTick[i] = (s_q.x2Mode && !periphStdSelect[i]) ? xtalRise
                                                                      : halfRise; // [RULE7]
      end
      // Six core ticks per machine cycle: 6 crystal periods in X2, 12 otherwise
      lastPhase = 4'(X2_PERIODS_PER_MC - 1); // [RULE1]
      if (s_d.ticks.cpuTick) begin
        if (s_q.phase >= lastPhase) begin
          s_d.phase              = PHASE_RESET;
          s_d.ticks.machineCycle = 1'b1;
        end else begin
          s_d.phase = s_q.phase + 4'h1;
        end
      end
    end
  end

  // Supply loss forces reset without a clock edge
  always_ff @(posedge mclk or posedge rst or posedge supplyLost) begin
    if (rst || supplyLost) begin
      s_q <= '{xtalLast: 1'b0, halfClk: 1'b0, x2Mode: 1'b0, bootTaken: 1'b0,
               phase: PHASE_RESET, ticks: '0, internalReset: 1'b1,
               toggling: 1'b0}; // [RULE13]
    end else begin
      s_q <= s_d;
    end
  end

  assign internalReset     = s_q.internalReset;
  assign cpuTick           = s_q.ticks.cpuTick;
  assign machineCycle      = s_q.ticks.machineCycle;
  assign periphTick        = s_q.ticks.periphTick;
  assign doubleSpeedActive = s_q.x2Mode;
  assign crystalToggling   = s_q.toggling;

endmodule // csr_clock_speed

// ---- bench/csr_crystal_model.sv ----
// Crystal oscillator model driving the crystal input pin
`timescale 1ns/1ps
module csr_crystal_model #(
  parameter int unsigned HALF_NS = 40
) (
  input  wire logic run,  // Oscillate while high
  output logic      xtal  // Crystal level
);
  // Edges kept off the system clock grid; level holds while stopped
  initial begin
    xtal = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      if (run) xtal = ~xtal;
    end
  end
endmodule // csr_crystal_model

// ---- bench/csr_clock_speed_checker.sv ----
// Concurrent checks on the ports of the clock speed block
`timescale 1ns/1ps
module csr_clock_speed_checker
  import csr_pkg::*;
#(
  parameter int unsigned RELEASE_COUNT = RELEASE_PERIODS
) (
  input wire logic                  mclk,              // Clock
  input wire logic                  rst,               // Reset
  input wire logic                  crystalInput,      // Crystal
  input wire logic                  supplyOk,          // Supply safe
  input wire logic                  doubleSpeedSelect, // CPU mode bit
  input wire logic [NUM_PERIPH-1:0] periphStdSelect,   // Keep standard
  input wire logic                  bootDoubleSpeed,   // Boot option
  input wire logic                  internalReset,     // Core reset
  input wire logic                  cpuTick,           // Core tick
  input wire logic                  machineCycle,      // Cycle pulse
  input wire logic [NUM_PERIPH-1:0] periphTick,        // Periph ticks
  input wire logic                  doubleSpeedActive, // Applied mode
  input wire logic                  crystalToggling    // Toggle seen
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] tickCnt_q;
  logic       mcSeen_q;
  // Ticks since the last machine cycle pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickCnt_q <= 4'h0;
      mcSeen_q  <= 1'b0;
    end else begin
      tickCnt_q <= machineCycle ? 4'h0 : tickCnt_q + {3'h0, cpuTick};
      mcSeen_q  <= ~internalReset & (mcSeen_q | machineCycle);
    end
  end
  chk_supply_drop: assert property (!supplyOk |-> internalReset)
    else $error("no reset on supply drop");
  chk_release_toggle: assert property ($fell(internalReset) |-> crystalToggling)
    else $error("release without crystal activity");
  chk_reset_mode: assert property (internalReset |-> !doubleSpeedActive)
    else $error("double speed during reset");
  chk_mc_six: assert property (machineCycle && mcSeen_q |-> tickCnt_q + {3'h0, cpuTick} == 4'h6)
    else $error("machine cycle not six ticks");
  chk_mode_rise: assert property ($rose(doubleSpeedActive) |-> $past(doubleSpeedSelect) || $past(bootDoubleSpeed))
    else $error("mode rose without request");
  chk_mode_fall: assert property ($fell(doubleSpeedActive) && !internalReset |-> !$past(doubleSpeedSelect))
    else $error("mode fell while selected");
  chk_std_follow: assert property (!internalReset && !doubleSpeedActive && !$past(doubleSpeedActive)
    |-> periphTick == {NUM_PERIPH{cpuTick}})
    else $error("peripheral rate differs in standard mode");
  chk_x2_follow: assert property (doubleSpeedActive && $past(doubleSpeedActive) && $stable(periphStdSelect)
    |-> (periphTick & ~periphStdSelect) == ({NUM_PERIPH{cpuTick}} & ~periphStdSelect))
    else $error("following peripheral off core rate");
  cover property (machineCycle && doubleSpeedActive);
  cover property ($fell(internalReset));
  cover property (!supplyOk);
endmodule // csr_clock_speed_checker

bind csr_clock_speed csr_clock_speed_checker #(.RELEASE_COUNT(RELEASE_COUNT)) i_chk (.mclk, .rst,
  .crystalInput, .supplyOk, .doubleSpeedSelect, .periphStdSelect, .bootDoubleSpeed, .internalReset,
  .cpuTick, .machineCycle, .periphTick, .doubleSpeedActive, .crystalToggling);

// ---- bench/test_cpu_clock_speed_and_reset_release.sv ----
// Self-checking testbench for the clock speed and reset release block
`timescale 1ns/1ps
module test_cpu_clock_speed_and_reset_release;
  import csr_pkg::*;
  localparam int unsigned RC = 8;
  logic                  mclk = 1'b0;
  logic                  rst = 1'b1;
  logic                  run = 1'b0;
  logic                  supplyOk = 1'b1;
  logic                  doubleSpeedSelect = 1'b0;
  logic [NUM_PERIPH-1:0] periphStdSelect = 7'h7F;
  logic                  bootDoubleSpeed = 1'b0;
  logic [NUM_PERIPH-1:0] periphTick;
  logic                  crystalInput, internalReset, cpuTick, machineCycle;
  logic                  doubleSpeedActive, crystalToggling, seen;
  int                    n_fail = 0;
  int                    samples_checked = 0;
  int                    falls = 0;
  int                    cnt [NUM_PERIPH+2];
  always #2.5 mclk = ~mclk;
  // Crystal falls counted between toggle detection and release
  always @(negedge crystalInput) if (crystalToggling === 1'b1 && internalReset === 1'b1) falls++;
  csr_crystal_model i_xtal (.run(run), .xtal(crystalInput));
  csr_clock_speed #(.RELEASE_COUNT(RC)) i_dut (.mclk, .rst, .crystalInput, .supplyOk,
    .doubleSpeedSelect, .periphStdSelect, .bootDoubleSpeed, .internalReset, .cpuTick,
    .machineCycle, .periphTick, .doubleSpeedActive, .crystalToggling);
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_release();
    int i;
    for (i = 0; i < 5000 && internalReset !== 1'b0; i++) @(posedge mclk);
    if (i == 5000) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // Counts over 768 cycles, a whole number of every tick period
  task automatic measure(logic x2);
    int i;
    for (i = 0; i < 100 && doubleSpeedActive !== x2; i++) @(posedge mclk);
    if (i == 100) begin
      n_fail++;
      report_and_stop();
    end
    check("mode", x2, doubleSpeedActive);
    repeat (2) @(posedge mclk);
    cnt = '{default: 0};
    repeat (768) begin
      @(posedge mclk);
      cnt[0] += cpuTick;
      cnt[1] += machineCycle;
      for (int b = 0; b < NUM_PERIPH; b++) cnt[b + 2] += periphTick[b];
    end
    check("cpu ticks", x2 ? 48 : 24, cnt[0]);
    check("machine cycles", x2 ? 8 : 4, cnt[1]);
    for (int b = 0; b < NUM_PERIPH; b++) check("periph ticks", (x2 && !periphStdSelect[b]) ? 48 : 24, cnt[b + 2]);
    $display("speed test done, mode %0b", x2);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (300) @(posedge mclk);
    check("reset held", 1, internalReset);
    run <= 1'b1;
    wait_release();
    check("release falls", RC, falls);
    check("mode after reset", 0, doubleSpeedActive);
    $display("release test done");
    periphStdSelect <= 7'h55;
    measure(1'b0);
    doubleSpeedSelect <= 1'b1;
    measure(1'b1);
    periphStdSelect <= 7'h2A;
    measure(1'b1);
    doubleSpeedSelect <= 1'b0;
    measure(1'b0);
    supplyOk <= 1'b0;
    #1;
    check("reset on drop", 1, internalReset);
    falls = 0;
    repeat (50) @(posedge mclk);
    supplyOk <= 1'b1;
    wait_release();
    check("falls after drop", RC, falls);
    $display("supply test done");
    bootDoubleSpeed <= 1'b1;
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    falls = 0;
    wait_release();
    check("falls after reset", RC, falls);
    seen = 1'b0;
    repeat (6) begin
      @(posedge mclk);
      seen = seen | doubleSpeedActive;
    end
    check("boot mode", 1, seen);
    $display("boot test done");
    report_and_stop();
  end
endmodule // test_cpu_clock_speed_and_reset_release
